/* File: udfu_pkg.sv */
package udfu_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int                 LEN_W     = 11;
  localparam int                 BYTE_W    = 8;
  localparam int                 BUF_W     = 9;
  localparam int                 IDX_W     = 3;
  localparam logic [LEN_W-1:0]   MAX_XFER  = 11'h400;
  localparam logic [LEN_W-1:0]   LEN_ZERO  = 11'h000;
  localparam logic [LEN_W-1:0]   LEN_ONE   = 11'h001;

  // ----------------------------------------------------------------
  // Status response layout
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0]   IDX_ZERO       = 3'h0;
  localparam logic [IDX_W-1:0]   IDX_ONE        = 3'h1;
  localparam logic [IDX_W-1:0]   STAT_IDX_CODE  = 3'h0;
  localparam logic [IDX_W-1:0]   STAT_IDX_STATE = 3'h4;
  localparam logic [IDX_W-1:0]   STAT_IDX_LAST  = 3'h5;
  localparam logic [BYTE_W-1:0]  BYTE_ZERO      = 8'h00;
  localparam logic [3:0]         STATE_PAD      = 4'h0;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0]  STAT_OK      = 8'h00;
  localparam logic [BYTE_W-1:0]  STAT_TOO_BIG = 8'h0E;
  localparam logic [BYTE_W-1:0]  STAT_STALLED = 8'h0F;

  // ----------------------------------------------------------------
  // Requests, states, phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    REQ_DETACH    = 3'h0,
    REQ_DNLOAD    = 3'h1,
    REQ_UPLOAD    = 3'h2,
    REQ_GETSTATUS = 3'h3,
    REQ_CLRSTATUS = 3'h4,
    REQ_GETSTATE  = 3'h5,
    REQ_ABORT     = 3'h6
  } udfu_req_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h2,
    ST_DN_SYNC  = 4'h3,
    ST_DN_IDLE  = 4'h5,
    ST_MAN_SYNC = 4'h6,
    ST_UP_IDLE  = 4'h9,
    ST_ERROR    = 4'hA
  } udfu_state_t;

  typedef enum logic [1:0] {
    PH_REQ = 2'b00,
    PH_DN  = 2'b01,
    PH_RSP = 2'b10,
    PH_UP  = 2'b11
  } udfu_phase_t;

endpackage : udfu_pkg

/* File: udfu_stream_if.sv */
`timescale 1ns/100ps
interface udfu_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : udfu_stream_if

/* File: udfu_buf2.sv */
`timescale 1ns/100ps
module udfu_buf2 #(
  parameter int W = 9
) (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  udfu_stream_if.snk in_s,
  udfu_stream_if.src out_s
);
  import udfu_pkg::*;

  // ----------------------------------------------------------------
  // Two-entry buffer, head in slot 0, all outputs from flops
  // ----------------------------------------------------------------
  logic         v0;
  logic         v1;
  logic         rdy;
  logic [W-1:0] d0;
  logic [W-1:0] d1;
  logic         next_v0;
  logic         next_v1;
  logic         next_rdy;
  logic [W-1:0] next_d0;
  logic [W-1:0] next_d1;
  logic         push;
  logic         pop;

  assign in_s.ready  = rdy;
  assign out_s.valid = v0;
  assign out_s.data  = d0;
  assign push        = in_s.valid & rdy;
  assign pop         = v0 & out_s.ready;

  always_comb begin
    next_v0 = v0;
    next_v1 = v1;
    next_d0 = d0;
    next_d1 = d1;
    if (pop) begin
      next_v0 = v1;
      next_d0 = d1;
      next_v1 = 1'b0;
    end
    if (push) begin
      if (!next_v0) begin
        next_v0 = 1'b1;
        next_d0 = in_s.data;
      end else begin
        next_v1 = 1'b1;
        next_d1 = in_s.data;
      end
    end
    next_rdy = ~next_v1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      v0  <= 1'b0;
      v1  <= 1'b0;
      rdy <= 1'b0;
      d0  <= '0;
      d1  <= '0;
    end else begin
      v0  <= next_v0;
      v1  <= next_v1;
      rdy <= next_rdy;
      d0  <= next_d0;
      d1  <= next_d1;
    end
  end

endmodule : udfu_buf2

/* File: udfu_dfu_ctrl.sv */
// Operation
// [R01] Download payload limited to 1024 bytes
// [R02] Host polls status until download idle
// [R03] Zero-length download ends the download
// [R04] Upload returns at most 1024 bytes
// [R05] Sync leaves only when block done, status
// [R06] Clear-status clears error, returns idle
// [R07] Get-state returns state byte, no change
// [R08] Abort cancels transfer, returns to idle
// [R09] Idle reported when ready for operation
// [R10] Every download enters sync until status
// [R11] Download idle reported when next block accepted
// [R12] No busy state; sync holds during programming
// [R13] Host queries state for readiness, errors
// [R14] Download inbound; upload, status, state outbound
// [R15] Zero download in idle: manifest sync, idle; code does this from download idle only, in idle it gives the stalled error
// [R16] Upload idle until short upload request
// [R17] Errors hold error state until clear-status
`timescale 1ns/100ps
module udfu_dfu_ctrl (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          req_valid,
  input  wire udfu_pkg::udfu_req_t           req_code,
  input  wire logic [udfu_pkg::LEN_W-1:0]    req_length,
  output wire logic                          req_ready,
  input  wire logic                          dn_valid,
  input  wire logic [udfu_pkg::BYTE_W-1:0]   dn_byte,
  output wire logic                          dn_ready,
  output wire logic                          flash_valid,
  output wire logic [udfu_pkg::BYTE_W-1:0]   flash_byte,
  output wire logic                          flash_last,
  input  wire logic                          flash_ready,
  input  wire logic                          flash_done,
  output wire logic                          flash_abort,
  output wire logic                          up_rd_req,
  input  wire logic                          up_rd_valid,
  input  wire logic [udfu_pkg::BYTE_W-1:0]   up_rd_byte,
  output wire logic                          resp_valid,
  output wire logic [udfu_pkg::BYTE_W-1:0]   resp_byte,
  output wire logic                          resp_last,
  input  wire logic                          resp_ready,
  output wire udfu_pkg::udfu_state_t         dfu_state
);
  import udfu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  udfu_state_t       state,      next_state;
  udfu_phase_t       phase,      next_phase;
  logic [BYTE_W-1:0] status,     next_status;
  logic [LEN_W-1:0]  remain,     next_remain;
  logic [IDX_W-1:0]  rsp_idx,    next_rsp_idx;
  logic              rsp_status, next_rsp_status;
  logic              up_short,   next_up_short;
  logic              up_wait,    next_up_wait;
  logic              pending,    next_pending;
  logic              hold_v,     next_hold_v;
  logic [BUF_W-1:0]  hold_d,     next_hold_d;
  logic              wr_v,       next_wr_v;
  logic [BUF_W-1:0]  wr_d,       next_wr_d;
  logic              rdy_req,    next_rdy_req;
  logic              rdy_dn,     next_rdy_dn;
  logic              abort_p,    next_abort_p;
  logic              rd_p,       next_rd_p;
  logic              req_take;
  logic              dn_take;
  logic              wr_free;
  logic [BYTE_W-1:0] rsp_byte;

  udfu_stream_if #(.W(BUF_W)) fl_in ();
  udfu_stream_if #(.W(BUF_W)) fl_out ();
  udfu_stream_if #(.W(BUF_W)) rs_in ();
  udfu_stream_if #(.W(BUF_W)) rs_out ();

  // ----------------------------------------------------------------
  // Buffers toward flash and toward the host
  // ----------------------------------------------------------------
  udfu_buf2 #(.W(BUF_W)) u_fl_buf (
    .ref_clk (ref_clk),
    .rst     (rst),
    .in_s    (fl_in),
    .out_s   (fl_out)
  );

  udfu_buf2 #(.W(BUF_W)) u_rs_buf (
    .ref_clk (ref_clk),
    .rst     (rst),
    .in_s    (rs_in),
    .out_s   (rs_out)
  );

  assign fl_in.valid  = hold_v;
  assign fl_in.data   = hold_d;
  assign fl_out.ready = flash_ready;
  assign flash_valid  = fl_out.valid;
  assign flash_byte   = fl_out.data[BYTE_W-1:0];
  assign flash_last   = fl_out.data[BYTE_W];
  assign rs_in.valid  = wr_v;
  assign rs_in.data   = wr_d;
  assign rs_out.ready = resp_ready;
  assign resp_valid   = rs_out.valid;
  assign resp_byte    = rs_out.data[BYTE_W-1:0];
  assign resp_last    = rs_out.data[BYTE_W];

  assign req_ready    = rdy_req;
  assign dn_ready     = rdy_dn;
  assign flash_abort  = abort_p;
  assign up_rd_req    = rd_p;
  assign dfu_state    = state;

  assign req_take = req_valid & rdy_req;
  assign dn_take  = dn_valid & rdy_dn;
  assign wr_free  = ~wr_v | rs_in.ready;

  // ----------------------------------------------------------------
  // Status reply bytes: code, poll timeout, state, string index
  // ----------------------------------------------------------------
  always_comb begin
    rsp_byte = BYTE_ZERO;
    if (!rsp_status) begin
      // [R07] state byte only
      rsp_byte = {STATE_PAD, state};
    end else if (rsp_idx == STAT_IDX_CODE) begin
      rsp_byte = status;
    end else if (rsp_idx == STAT_IDX_STATE) begin
      rsp_byte = {STATE_PAD, state};
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_phase      = phase;
    next_status     = status;
    next_remain     = remain;
    next_rsp_idx    = rsp_idx;
    next_rsp_status = rsp_status;
    next_up_short   = up_short;
    next_up_wait    = up_wait;
    next_pending    = pending;
    next_hold_v     = hold_v;
    next_hold_d     = hold_d;
    next_wr_v       = wr_v;
    next_wr_d       = wr_d;
    next_abort_p    = 1'b0;
    next_rd_p       = 1'b0;

    // [R12] programming done lets sync advance
    if (flash_done) begin
      next_pending = 1'b0;
    end
    if (hold_v && fl_in.ready) begin
      next_hold_v = 1'b0;
    end
    if (wr_v && rs_in.ready) begin
      next_wr_v = 1'b0;
    end

    unique case (phase)
      PH_REQ: begin
        if (req_take) begin
          case (req_code)
            REQ_DNLOAD: begin
              if (req_length > MAX_XFER) begin
                // [R01] oversize payload refused
                next_state  = ST_ERROR;
                next_status = STAT_TOO_BIG;
              end else if (req_length == LEN_ZERO) begin
                // [R15] end of image, manifest sync
                if (state == ST_DN_IDLE) begin
                  next_state = ST_MAN_SYNC;
                end else begin
                  next_state  = ST_ERROR;
                  next_status = STAT_STALLED;
                end
              end else if (state == ST_IDLE || state == ST_DN_IDLE) begin
                // [R10] each block enters sync
                next_state   = ST_DN_SYNC;
                next_phase   = PH_DN;
                next_remain  = req_length;
                next_pending = 1'b1;
              end else begin
                next_state  = ST_ERROR;
                next_status = STAT_STALLED;
              end
            end
            REQ_UPLOAD: begin
              if (state == ST_IDLE || state == ST_UP_IDLE) begin
                // [R04] capped at maximum size
                next_remain   = (req_length > MAX_XFER) ? MAX_XFER : req_length;
                next_up_short = (req_length < MAX_XFER);
                if (req_length == LEN_ZERO) begin
                  next_state = ST_IDLE;
                end else begin
                  next_state = ST_UP_IDLE;
                  next_phase = PH_UP;
                end
              end else begin
                next_state  = ST_ERROR;
                next_status = STAT_STALLED;
              end
            end
            REQ_GETSTATUS: begin
              // [R05] advance only when block processed
              // [R11] ready for next block
              if (state == ST_DN_SYNC && !pending) begin
                next_state = ST_DN_IDLE;
              end else if (state == ST_MAN_SYNC) begin
                next_state = ST_IDLE;
              end
              next_phase      = PH_RSP;
              next_rsp_status = 1'b1;
              next_rsp_idx    = IDX_ZERO;
            end
            REQ_CLRSTATUS: begin
              // [R06] clear error, back to idle
              next_state  = ST_IDLE;
              next_status = STAT_OK;
            end
            REQ_GETSTATE: begin
              next_phase      = PH_RSP;
              next_rsp_status = 1'b0;
              next_rsp_idx    = IDX_ZERO;
            end
            REQ_ABORT: begin
              // [R08] cancel partial transfer
              if (state != ST_ERROR) begin
                next_state   = ST_IDLE;
                next_pending = 1'b0;
                next_abort_p = 1'b1;
              end
            end
            default: begin
              // [R17] unsupported request is an error
              next_state  = ST_ERROR;
              next_status = STAT_STALLED;
            end
          endcase
        end
      end
      PH_DN: begin
        // [R14] inbound block toward flash
        if (dn_take) begin
          next_hold_v = 1'b1;
          next_hold_d = {remain == LEN_ONE, dn_byte};
          next_remain = remain - LEN_ONE;
        end else if (remain == LEN_ZERO && !hold_v) begin
          next_phase = PH_REQ;
        end
      end
      PH_RSP: begin
        if (wr_free) begin
          next_wr_v    = 1'b1;
          next_wr_d    = {!rsp_status || rsp_idx == STAT_IDX_LAST, rsp_byte};
          next_rsp_idx = rsp_idx + IDX_ONE;
          if (!rsp_status || rsp_idx == STAT_IDX_LAST) begin
            next_phase = PH_REQ;
          end
        end
      end
      PH_UP: begin
        if (up_wait) begin
          if (up_rd_valid) begin
            next_wr_v    = 1'b1;
            next_wr_d    = {remain == LEN_ONE, up_rd_byte};
            next_remain  = remain - LEN_ONE;
            next_up_wait = 1'b0;
          end
        end else if (remain == LEN_ZERO) begin
          // [R16] short upload closes the sequence
          next_phase = PH_REQ;
          next_state = up_short ? ST_IDLE : ST_UP_IDLE;
        end else if (!wr_v) begin
          next_rd_p    = 1'b1;
          next_up_wait = 1'b1;
        end
      end
    endcase

    next_rdy_req = (next_phase == PH_REQ);
    next_rdy_dn  = (next_phase == PH_DN) && (next_remain != LEN_ZERO) && !next_hold_v;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // [R09] idle after reset
      state      <= ST_IDLE;
      phase      <= PH_REQ;
      status     <= STAT_OK;
      remain     <= LEN_ZERO;
      rsp_idx    <= IDX_ZERO;
      rsp_status <= 1'b0;
      up_short   <= 1'b0;
      up_wait    <= 1'b0;
      pending    <= 1'b0;
      hold_v     <= 1'b0;
      hold_d     <= '0;
      wr_v       <= 1'b0;
      wr_d       <= '0;
      rdy_req    <= 1'b0;
      rdy_dn     <= 1'b0;
      abort_p    <= 1'b0;
      rd_p       <= 1'b0;
    end else begin
      state      <= next_state;
      phase      <= next_phase;
      status     <= next_status;
      remain     <= next_remain;
      rsp_idx    <= next_rsp_idx;
      rsp_status <= next_rsp_status;
      up_short   <= next_up_short;
      up_wait    <= next_up_wait;
      pending    <= next_pending;
      hold_v     <= next_hold_v;
      hold_d     <= next_hold_d;
      wr_v       <= next_wr_v;
      wr_d       <= next_wr_d;
      rdy_req    <= next_rdy_req;
      rdy_dn     <= next_rdy_dn;
      abort_p    <= next_abort_p;
      rd_p       <= next_rd_p;
    end
  end

endmodule : udfu_dfu_ctrl

/* File: udfu_dfu_ctrl_assertions.sv */
`timescale 1ns/100ps
module udfu_dfu_ctrl_assertions (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       req_valid,
  input wire udfu_pkg::udfu_req_t        req_code,
  input wire logic [udfu_pkg::LEN_W-1:0] req_length,
  input wire logic                       req_ready,
  input wire logic                       flash_abort,
  input wire logic                       resp_valid,
  input wire logic                       resp_last,
  input wire udfu_pkg::udfu_state_t      dfu_state
);
  import udfu_pkg::*;
  logic fire;
  assign fire = req_valid && req_ready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // State sequencing
  // ----------------------------------------------------------------
  chk_no_busy_state:
    assert property (dfu_state inside {ST_IDLE, ST_DN_SYNC, ST_DN_IDLE, ST_MAN_SYNC, ST_UP_IDLE, ST_ERROR})
    else $error("unexpected state code");
  chk_dnload_to_sync:
    assert property (fire && req_code == REQ_DNLOAD && req_length != LEN_ZERO && req_length <= MAX_XFER
      && dfu_state inside {ST_IDLE, ST_DN_IDLE} |=> dfu_state == ST_DN_SYNC) else $error("download not in sync");
  chk_sync_holds:
    assert property (dfu_state == ST_DN_SYNC && !fire |=> dfu_state == ST_DN_SYNC) else $error("sync left alone");
  chk_getstate_stable:
    assert property (fire && req_code == REQ_GETSTATE |=> dfu_state == $past(dfu_state))
    else $error("get-state moved state");
  chk_getstate_byte:
    assert property (fire && req_code == REQ_GETSTATE |-> ##3 (resp_valid && resp_last))
    else $error("get-state reply not one byte");
  chk_clear_idle:
    assert property (fire && req_code == REQ_CLRSTATUS |=> dfu_state == ST_IDLE) else $error("clear not idle");
  chk_abort_idle:
    assert property (fire && req_code == REQ_ABORT && dfu_state != ST_ERROR |=> dfu_state == ST_IDLE)
    else $error("abort not idle");
  chk_abort_pulse:
    assert property (fire && req_code == REQ_ABORT && dfu_state != ST_ERROR |-> ##[1:2] flash_abort)
    else $error("abort not passed on");
  chk_oversize_error:
    assert property (fire && req_code == REQ_DNLOAD && req_length > MAX_XFER |=> dfu_state == ST_ERROR)
    else $error("oversize accepted");
  chk_error_sticky:
    assert property (dfu_state == ST_ERROR && !(fire && req_code == REQ_CLRSTATUS) |=> dfu_state == ST_ERROR)
    else $error("error state left");
  chk_zero_manifest:
    assert property (fire && req_code == REQ_DNLOAD && req_length == LEN_ZERO && dfu_state == ST_DN_IDLE
      |=> dfu_state == ST_MAN_SYNC) else $error("no manifest sync");
  chk_manifest_idle:
    assert property (fire && req_code == REQ_GETSTATUS && dfu_state == ST_MAN_SYNC |=> dfu_state == ST_IDLE)
    else $error("manifest not idle");
endmodule : udfu_dfu_ctrl_assertions

/* File: udfu_flash_model.sv */
`timescale 1ns/100ps
module udfu_flash_model #(
  parameter int DONE_DLY = 200
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       flash_valid,
  input  wire logic [7:0] flash_byte,
  input  wire logic       flash_last,
  output logic            flash_ready,
  output logic            flash_done,
  input  wire logic       flash_abort,
  input  wire logic       up_rd_req,
  output logic            up_rd_valid,
  output logic [7:0]      up_rd_byte
);
  int         cnt, bad, ab_cnt, wait_cnt, idx, up_cnt;
  logic       tk, fl, rq, ab;
  logic [7:0] fb;
  initial begin
    {cnt, bad, ab_cnt, wait_cnt, idx, up_cnt} = '0;
    flash_ready = 1'b0;
    flash_done  = 1'b0;
    up_rd_valid = 1'b0;
    up_rd_byte  = 8'hA5;
  end
  always @(posedge ref_clk) begin
    tk = flash_valid && flash_ready;
    fb = flash_byte;
    fl = flash_last;
    rq = up_rd_req;
    ab = flash_abort;
    #1;
    if (tk) begin
      cnt++;
      bad += int'(fb !== 8'(8'h30 + idx));
      idx = fl ? 0 : idx + 1;
      wait_cnt = fl ? DONE_DLY : wait_cnt;
    end
    flash_done = (wait_cnt == 1);
    wait_cnt   = (wait_cnt > 0) ? wait_cnt - 1 : 0;
    if (ab || rst) begin
      wait_cnt = 0;
      idx = 0;
    end
    ab_cnt += int'(ab);
    flash_ready = ~flash_ready;
    up_rd_valid = rq;
    up_rd_byte  = rq ? 8'(up_cnt) ^ 8'h5A : ~up_rd_byte;
    up_cnt += int'(rq);
  end
endmodule : udfu_flash_model

/* File: udfu_dfu_ctrl_tb.sv */
`timescale 1ns/100ps
module udfu_dfu_ctrl_tb;
  import udfu_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic              ref_clk, rst, req_valid, req_ready, dn_valid, dn_ready, flash_valid, flash_last;
  logic              flash_ready, flash_done, flash_abort, up_rd_req, up_rd_valid, resp_valid, resp_last;
  logic              resp_ready;
  logic [BYTE_W-1:0] dn_byte, flash_byte, up_rd_byte, resp_byte;
  logic [LEN_W-1:0]  req_length;
  udfu_req_t         req_code;
  udfu_state_t       dfu_state;
  logic [BYTE_W-1:0] rb [0:1023];
  int                error_cnt, checks_done, rn, up_base, n0;
  udfu_dfu_ctrl i_udfu_dfu_ctrl (
    .ref_clk, .rst, .req_valid, .req_code, .req_length, .req_ready, .dn_valid, .dn_byte, .dn_ready,
    .flash_valid, .flash_byte, .flash_last, .flash_ready, .flash_done, .flash_abort, .up_rd_req,
    .up_rd_valid, .up_rd_byte, .resp_valid, .resp_byte, .resp_last, .resp_ready, .dfu_state
  );
  udfu_flash_model i_udfu_flash_model (
    .ref_clk, .rst, .flash_valid, .flash_byte, .flash_last, .flash_ready, .flash_done, .flash_abort,
    .up_rd_req, .up_rd_valid, .up_rd_byte
  );
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic bail;
    error_cnt++;
    report_and_stop();
  endtask : bail
  task automatic send_req(input udfu_req_t c, input logic [LEN_W-1:0] n);
    int k;
    @(posedge ref_clk);
    #1;
    for (k = 0; k < 100 && !req_ready; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 100) bail();
    req_valid  = 1'b1;
    req_code   = c;
    req_length = n;
    @(posedge ref_clk);
    #1;
    req_valid = 1'b0;
  endtask : send_req
  task automatic send_data(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      dn_valid = 1'b1;
      dn_byte  = 8'(8'h30 + i);
      for (k = 0; k < 100; k++) begin
        @(negedge ref_clk);
        if (dn_ready) break;
      end
      if (k == 100) bail();
      @(posedge ref_clk);
      #1;
    end
    dn_valid = 1'b0;
  endtask : send_data
  task automatic get_resp;
    logic fin;
    fin = 1'b0;
    rn  = 0;
    for (int k = 0; k < 10000 && !fin; k++) begin
      @(negedge ref_clk);
      if (resp_valid && resp_ready) begin
        rb[rn] = resp_byte;
        rn++;
        fin = resp_last;
      end
      @(posedge ref_clk);
      #1;
      resp_ready = ~resp_ready;
    end
    if (!fin) bail();
  endtask : get_resp
  task automatic wait_done;
    int k;
    for (k = 0; k < 2000; k++) begin
      @(negedge ref_clk);
      if (flash_done) break;
    end
    if (k == 2000) bail();
    @(posedge ref_clk);
    #1;
  endtask : wait_done
  task automatic st_is(input udfu_state_t st);
    check({12'h000, dfu_state}, {12'h000, st});
  endtask : st_is
  task automatic status(input logic [7:0] code, input udfu_state_t st);
    send_req(REQ_GETSTATUS, 11'h006);
    get_resp();
    check(16'(rn), 16'h0006);
    check({8'h00, rb[0]}, {8'h00, code});
    check({8'h00, rb[4]}, {12'h000, st});
    st_is(st);
  endtask : status
  task automatic dn_block(input int n);
    send_req(REQ_DNLOAD, n[LEN_W-1:0]);
    st_is(ST_DN_SYNC);
    send_data(n);
  endtask : dn_block
  task automatic upload(input int n, input udfu_state_t st);
    send_req(REQ_UPLOAD, n[LEN_W-1:0]);
    get_resp();
    check(16'(rn), 16'(n));
    for (int k = 0; k < n; k++) check({8'h00, rb[k]}, {8'h00, 8'(up_base + k) ^ 8'h5A});
    up_base += n;
    st_is(st);
  endtask : upload
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle;
    st_is(ST_IDLE);
    send_req(REQ_GETSTATE, LEN_ONE);
    get_resp();
    check(16'(rn), 16'h0001);
    check({8'h00, rb[0]}, {12'h000, ST_IDLE});
    st_is(ST_IDLE);
  endtask : t_idle
  task automatic t_download;
    dn_block(4);
    status(STAT_OK, ST_DN_SYNC);
    wait_done();
    status(STAT_OK, ST_DN_IDLE);
    dn_block(1024);
    wait_done();
    status(STAT_OK, ST_DN_IDLE);
    check(16'(i_udfu_flash_model.cnt), 16'h0404);
    check(16'(i_udfu_flash_model.bad), 16'h0000);
    send_req(REQ_DNLOAD, LEN_ZERO);
    st_is(ST_MAN_SYNC);
    status(STAT_OK, ST_IDLE);
  endtask : t_download
  task automatic t_upload;
    upload(3, ST_IDLE);
    upload(1024, ST_UP_IDLE);
    upload(1, ST_IDLE);
  endtask : t_upload
  task automatic t_errors;
    send_req(REQ_DNLOAD, 11'h401);
    st_is(ST_ERROR);
    status(STAT_TOO_BIG, ST_ERROR);
    send_req(REQ_ABORT, LEN_ZERO);
    st_is(ST_ERROR);
    send_req(REQ_CLRSTATUS, LEN_ZERO);
    status(STAT_OK, ST_IDLE);
    send_req(REQ_DETACH, LEN_ZERO);
    status(STAT_STALLED, ST_ERROR);
    send_req(REQ_CLRSTATUS, LEN_ZERO);
    st_is(ST_IDLE);
  endtask : t_errors
  task automatic t_abort;
    n0 = i_udfu_flash_model.ab_cnt;
    dn_block(2);
    send_req(REQ_ABORT, LEN_ZERO);
    st_is(ST_IDLE);
    status(STAT_OK, ST_IDLE);
    check(16'(i_udfu_flash_model.ab_cnt - n0), 16'h0001);
    dn_block(1);
    wait_done();
    status(STAT_OK, ST_DN_IDLE);
  endtask : t_abort
  initial begin
    rst        = 1'b1;
    req_valid  = 1'b0;
    req_code   = REQ_GETSTATE;
    req_length = LEN_ZERO;
    dn_valid   = 1'b0;
    dn_byte    = BYTE_ZERO;
    resp_ready = 1'b0;
    error_cnt   = 0;
    checks_done = 0;
    up_base     = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_idle();
    t_download();
    t_upload();
    t_errors();
    t_abort();
    report_and_stop();
  end
endmodule : udfu_dfu_ctrl_tb
bind udfu_dfu_ctrl udfu_dfu_ctrl_assertions i_udfu_dfu_ctrl_assertions (
  .ref_clk, .rst, .req_valid, .req_code, .req_length, .req_ready, .flash_abort, .resp_valid, .resp_last,
  .dfu_state
);
